/* File: cesbt_pkg.sv */
// Package with register map, field layout, reset values and carrier types
package cesbt_pkg;

	// Register byte addresses
	localparam logic [31:0] ADDR_CONTROL = 32'h40050000;
	localparam logic [31:0] ADDR_STATUS  = 32'h40050004;
	localparam logic [31:0] ADDR_ERRCNT  = 32'h40050008;
	localparam logic [31:0] ADDR_BITTIME = 32'h4005000c;

	// Control register fields
	localparam int CTL_INIT_BIT = 0;
	localparam int CTL_CCE_BIT  = 6;
	localparam logic CTL_INIT_RST = 1'h1;
	localparam logic CTL_CCE_RST  = 1'h0;

	// Status register fields
	localparam int ST_PASSIVE_BIT = 5;
	localparam int ST_WARN_BIT    = 6;
	localparam int ST_BUSOFF_BIT  = 7;

	// Error counter register fields
	localparam int EC_TEC_LSB = 0;
	localparam int EC_TEC_MSB = 7;
	localparam int EC_REC_LSB = 8;
	localparam int EC_REC_MSB = 14;
	localparam int EC_RP_BIT  = 15;

	// Bit timing register fields and reset values
	localparam int BT_BRP_LSB  = 0;
	localparam int BT_BRP_MSB  = 5;
	localparam int BT_SJW_LSB  = 6;
	localparam int BT_SJW_MSB  = 7;
	localparam int BT_TS1_LSB  = 8;
	localparam int BT_TS1_MSB  = 11;
	localparam int BT_TS2_LSB  = 12;
	localparam int BT_TS2_MSB  = 14;
	localparam logic [5:0] BT_BRP_RST = 6'h01;
	localparam logic [1:0] BT_SJW_RST = 2'h0;
	localparam logic [3:0] BT_TS1_RST = 4'h3;
	localparam logic [2:0] BT_TS2_RST = 3'h2;

	// Fault confinement limits
	localparam logic [7:0] WARN_LIMIT     = 8'h60;
	localparam logic [7:0] PASSIVE_LIMIT  = 8'h80;
	localparam logic [7:0] REC_RELOAD     = 8'h78;
	localparam logic [8:0] TEC_MAX        = 9'h0ff;
	localparam logic [8:0] ERR_STEP_BIG   = 9'h008;

	// APB request from the master
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] paddr;
		logic [31:0] pwdata;
	} cesbt_apb_req_t;

	// APB answer to the master
	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} cesbt_apb_rsp_t;

	// Error events from the frame engine, one-cycle pulses
	typedef struct packed {
		logic txAdd8;
		logic txDec1;
		logic rxAdd1;
		logic rxAdd8;
		logic rxDec1;
		logic recover;
	} cesbt_err_evt_t;

	// Bit timing segment states
	typedef enum logic [1:0] {SEG_SYNC, SEG_BEFORE, SEG_AFTER} cesbt_seg_t;

endpackage

/* File: cesbt_core.sv */
// Error state reporting and bit timing logic with APB register access
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module cesbt_core
(
	input  wire logic                    sys_clk,     // System clock, 125 MHz
	input  wire logic                    resetn,      // Asynchronous reset, low active
	input  wire cesbt_pkg::cesbt_apb_req_t apbReq,    // APB request
	output var   cesbt_pkg::cesbt_apb_rsp_t apbRsp,   // APB answer
	input  wire cesbt_pkg::cesbt_err_evt_t errEvt,    // Error events from frame engine
	input  wire logic                    canRx,       // Bus receive pin
	output logic                         quantumTick, // One pulse per time quantum
	output logic                         samplePulse, // Pulse at the sample point
	output logic                         sampledBit,  // Bus level taken at sample point
	output logic                         busOffOut    // Controller is bus-off
);

	// Register decode
	function automatic logic hit(input logic [31:0] a, input logic [31:0] b);
		hit = (a == b);
	endfunction

	logic        setupPhase;
	logic        hitCtl;
	logic        hitSt;
	logic        hitEc;
	logic        hitBt;
	logic        hitAny;
	logic        wrAccess;

	assign setupPhase = apbReq.psel & ~apbReq.penable;
	assign hitCtl     = hit(apbReq.paddr, cesbt_pkg::ADDR_CONTROL);
	assign hitSt      = hit(apbReq.paddr, cesbt_pkg::ADDR_STATUS);
	assign hitEc      = hit(apbReq.paddr, cesbt_pkg::ADDR_ERRCNT);
	assign hitBt      = hit(apbReq.paddr, cesbt_pkg::ADDR_BITTIME);
	assign hitAny     = hitCtl | hitSt | hitEc | hitBt;
	assign wrAccess   = apbReq.psel & apbReq.penable & apbRsp.pready & apbReq.pwrite;

	// Control and bit timing registers
	logic       init_r;
	logic       cce_r;
	logic [5:0] brp_r;
	logic [1:0] sjw_r;
	logic [3:0] ts1_r;
	logic [2:0] ts2_r;
	logic       btWrite;

	assign btWrite = wrAccess & hitBt & init_r & cce_r;

	// Control register write
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			init_r <= cesbt_pkg::CTL_INIT_RST;
			cce_r  <= cesbt_pkg::CTL_CCE_RST;
		end
		else if (wrAccess & hitCtl)
		begin
			init_r <= apbReq.pwdata[cesbt_pkg::CTL_INIT_BIT];
			cce_r  <= apbReq.pwdata[cesbt_pkg::CTL_CCE_BIT];
		end
	end

	// Bit timing register write, gated by init and change enable
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			brp_r <= cesbt_pkg::BT_BRP_RST;
			sjw_r <= cesbt_pkg::BT_SJW_RST;
			ts1_r <= cesbt_pkg::BT_TS1_RST;
			ts2_r <= cesbt_pkg::BT_TS2_RST;
		end
		else if (btWrite)
		begin
			brp_r <= apbReq.pwdata[cesbt_pkg::BT_BRP_MSB:cesbt_pkg::BT_BRP_LSB];
			sjw_r <= apbReq.pwdata[cesbt_pkg::BT_SJW_MSB:cesbt_pkg::BT_SJW_LSB];
			ts1_r <= apbReq.pwdata[cesbt_pkg::BT_TS1_MSB:cesbt_pkg::BT_TS1_LSB];
			ts2_r <= apbReq.pwdata[cesbt_pkg::BT_TS2_MSB:cesbt_pkg::BT_TS2_LSB];
		end
	end

	// Error counters and fault confinement
	logic [8:0] tec_r;
	logic [8:0] tecSum;
	logic [8:0] tec_nxt;
	logic [7:0] rec_r;
	logic [7:0] rec_nxt;
	logic       busOff_r;
	logic       busOff_nxt;
	logic       tecDec;

	assign tecDec = errEvt.txDec1 & (tec_r != 9'h000);
	assign tecSum = tec_r + (errEvt.txAdd8 ? cesbt_pkg::ERR_STEP_BIG : 9'h000)
		- {8'h00, tecDec};

	// Next transmit count and bus-off entry
	always_comb
	begin
		tec_nxt    = tec_r;
		busOff_nxt = busOff_r;
		if (errEvt.recover)
		begin
			tec_nxt    = 9'h000;
			busOff_nxt = 1'b0;
		end
		else if (!busOff_r)
		begin
			if (tecSum > cesbt_pkg::TEC_MAX)
			begin
				tec_nxt    = cesbt_pkg::TEC_MAX;
				busOff_nxt = 1'b1;
			end
			else
			begin
				tec_nxt = tecSum;
			end
		end
	end

	// Next receive count, passive level reload on success
	always_comb
	begin
		rec_nxt = rec_r;
		if (errEvt.recover)
		begin
			rec_nxt = 8'h00;
		end
		else if (!busOff_r)
		begin
			if (errEvt.rxAdd8)
			begin
				rec_nxt = (rec_r > 8'hf7) ? 8'hff : rec_r + 8'h08;
			end
			else if (errEvt.rxAdd1)
			begin
				rec_nxt = (rec_r == 8'hff) ? 8'hff : rec_r + 8'h01;
			end
			else if (errEvt.rxDec1)
			begin
				if (rec_r >= cesbt_pkg::PASSIVE_LIMIT)
				begin
					rec_nxt = cesbt_pkg::REC_RELOAD;
				end
				else if (rec_r != 8'h00)
				begin
					rec_nxt = rec_r - 8'h01;
				end
			end
		end
	end

	// Counter state
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			tec_r    <= 9'h000;
			rec_r    <= 8'h00;
			busOff_r <= 1'b0;
		end
		else
		begin
			tec_r    <= tec_nxt;
			rec_r    <= rec_nxt;
			busOff_r <= busOff_nxt;
		end
	end

	// Derived flags
	logic errPassive;
	logic errWarning;
	logic rxPassive;

	assign rxPassive  = rec_r >= cesbt_pkg::PASSIVE_LIMIT;
	assign errPassive = (tec_r >= {1'b0, cesbt_pkg::PASSIVE_LIMIT}) | rxPassive;
	assign errWarning = (tec_r >= {1'b0, cesbt_pkg::WARN_LIMIT})
		| (rec_r >= cesbt_pkg::WARN_LIMIT);
	assign busOffOut  = busOff_r;

	// Read data selection
	logic [31:0] rdCtl;
	logic [31:0] rdSt;
	logic [31:0] rdEc;
	logic [31:0] rdBt;
	logic [31:0] rdSel;

	assign rdCtl = {25'h0, cce_r, 5'h0, init_r};
	assign rdSt  = {24'h0, busOff_r, errWarning, errPassive, 5'h0};
	assign rdEc  = {16'h0, rxPassive, rec_r[6:0], tec_r[7:0]};
	assign rdBt  = {17'h0, ts2_r, ts1_r, sjw_r, brp_r};
	assign rdSel = hitCtl ? rdCtl : hitSt ? rdSt : hitEc ? rdEc : hitBt ? rdBt : 32'h0;

	// APB answer, ready in the first access cycle
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			apbRsp <= '0;
		end
		else
		begin
			apbRsp.pready  <= setupPhase;
			apbRsp.pslverr <= setupPhase & ~hitAny;
			apbRsp.prdata  <= (setupPhase & ~apbReq.pwrite) ? rdSel : 32'h0;
		end
	end

	// Bus pin synchroniser, three stages
	logic [2:0] rxSync_r;
	logic       rxLevel_r;
	logic       rxPrev_r;

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rxSync_r  <= 3'h7;
			rxLevel_r <= 1'b1;
			rxPrev_r  <= 1'b1;
		end
		else
		begin
			rxSync_r <= {rxSync_r[1:0], canRx};
			if (rxSync_r[1] == rxSync_r[2])
			begin
				rxLevel_r <= rxSync_r[2];
			end
			rxPrev_r <= rxLevel_r;
		end
	end

	// Recessive to dominant edge, held until the next quantum
	logic edgeNow;
	logic edgeSeen_r;

	assign edgeNow = rxPrev_r & ~rxLevel_r;

	// Time quantum prescaler
	logic [5:0] preCnt_r;
	logic       qTick;

	assign qTick = ~init_r & (preCnt_r == brp_r);

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			preCnt_r <= 6'h00;
		end
		else if (init_r | qTick)
		begin
			preCnt_r <= 6'h00;
		end
		else
		begin
			preCnt_r <= preCnt_r + 6'h01;
		end
	end

	assign quantumTick = qTick;

	// Bit segment sequencer with resynchronisation
	cesbt_pkg::cesbt_seg_t seg_r;
	cesbt_pkg::cesbt_seg_t seg_nxt;
	logic [4:0] qCnt_r;
	logic [4:0] qCnt_nxt;
	logic [4:0] segLen_r;
	logic [4:0] segLen_nxt;
	logic       resynced_r;
	logic       resynced_nxt;
	logic       sample_nxt;
	logic [4:0] sjwQ;
	logic [4:0] ts1Q;
	logic [4:0] ts2Q;
	logic [4:0] remain;
	logic       edgeUse;

	assign sjwQ    = {3'h0, sjw_r} + 5'h01;
	assign ts1Q    = {1'h0, ts1_r} + 5'h01;
	assign ts2Q    = {2'h0, ts2_r} + 5'h01;
	assign remain  = segLen_r - qCnt_r;
	assign edgeUse = (edgeSeen_r | edgeNow) & ~resynced_r;

	// Segment next state, one step per quantum
	always_comb
	begin
		seg_nxt      = seg_r;
		qCnt_nxt     = qCnt_r;
		segLen_nxt   = segLen_r;
		resynced_nxt = resynced_r;
		sample_nxt   = 1'b0;
		case (seg_r)
			cesbt_pkg::SEG_SYNC:
			begin
				seg_nxt      = cesbt_pkg::SEG_BEFORE;
				qCnt_nxt     = 5'h00;
				segLen_nxt   = ts1Q;
				resynced_nxt = 1'b0;
			end
			cesbt_pkg::SEG_BEFORE:
			begin
				if (edgeUse)
				begin
					segLen_nxt   = segLen_r + ((qCnt_r < sjwQ) ? qCnt_r : sjwQ);
					resynced_nxt = 1'b1;
				end
				if (qCnt_r + 5'h01 >= segLen_nxt)
				begin
					seg_nxt    = cesbt_pkg::SEG_AFTER;
					qCnt_nxt   = 5'h00;
					segLen_nxt = ts2Q;
					sample_nxt = 1'b1;
				end
				else
				begin
					qCnt_nxt = qCnt_r + 5'h01;
				end
			end
			cesbt_pkg::SEG_AFTER:
			begin
				if (edgeUse && remain <= sjwQ)
				begin
					seg_nxt      = cesbt_pkg::SEG_BEFORE;
					qCnt_nxt     = 5'h00;
					segLen_nxt   = ts1Q;
					resynced_nxt = 1'b0;
				end
				else
				begin
					if (edgeUse)
					begin
						segLen_nxt   = segLen_r - sjwQ;
						resynced_nxt = 1'b1;
					end
					if (qCnt_r + 5'h01 >= segLen_nxt)
					begin
						seg_nxt  = cesbt_pkg::SEG_SYNC;
						qCnt_nxt = 5'h00;
					end
					else
					begin
						qCnt_nxt = qCnt_r + 5'h01;
					end
				end
			end
			default:
			begin
				seg_nxt  = cesbt_pkg::SEG_SYNC;
				qCnt_nxt = 5'h00;
			end
		endcase
	end

	// Segment state, advanced on quantum ticks
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			seg_r      <= cesbt_pkg::SEG_SYNC;
			qCnt_r     <= 5'h00;
			segLen_r   <= 5'h00;
			resynced_r <= 1'b0;
		end
		else if (init_r)
		begin
			seg_r      <= cesbt_pkg::SEG_SYNC;
			qCnt_r     <= 5'h00;
			resynced_r <= 1'b0;
		end
		else if (qTick)
		begin
			seg_r      <= seg_nxt;
			qCnt_r     <= qCnt_nxt;
			segLen_r   <= segLen_nxt;
			resynced_r <= resynced_nxt;
		end
	end

	// Edge memory and sample point outputs
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			edgeSeen_r  <= 1'b0;
			samplePulse <= 1'b0;
			sampledBit  <= 1'b1;
		end
		else
		begin
			edgeSeen_r  <= ~init_r & ~qTick & (edgeSeen_r | edgeNow);
			samplePulse <= qTick & sample_nxt;
			if (qTick & sample_nxt)
			begin
				sampledBit <= rxLevel_r;
			end
		end
	end

endmodule

`default_nettype wire

/* File: cesbt_bus_node.sv */
// Far-side bus node model driving the receive pin
`timescale 1ns/1ps
`default_nettype none

module cesbt_bus_node
(
	input  wire logic dominant, // Node pulls the bus dominant
	output logic      canRx     // Bus level seen by the block
);
	// Bus rests recessive through its pull-up when no node drives it
	assign canRx = dominant ? 1'b0 : 1'b1;
endmodule

`default_nettype wire

/* File: cesbt_core_chk.sv */
// Port checker for the error state and bit timing block
`timescale 1ns/1ps
`default_nettype none

module cesbt_core_chk
(
	input wire logic                      sys_clk,     // System clock
	input wire logic                      resetn,      // Reset, low active
	input wire cesbt_pkg::cesbt_apb_req_t apbReq,      // APB request
	input wire cesbt_pkg::cesbt_apb_rsp_t apbRsp,      // APB answer
	input wire cesbt_pkg::cesbt_err_evt_t errEvt,      // Error events
	input wire logic                      canRx,       // Bus pin
	input wire logic                      quantumTick, // Quantum pulse
	input wire logic                      samplePulse, // Sample point pulse
	input wire logic                      sampledBit,  // Sampled level
	input wire logic                      busOffOut    // Bus-off level
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	// Register bus answer timing and content
	a_ready_after_setup: assert property (apbReq.psel && !apbReq.penable |=> apbRsp.pready)
		else $error("no ready after setup");
	a_ready_in_access: assert property (apbRsp.pready |-> apbReq.psel && apbReq.penable)
		else $error("ready outside access");
	a_ready_single: assert property (apbRsp.pready |=> !apbRsp.pready)
		else $error("ready longer than one cycle");
	a_slverr_with_ready: assert property (apbRsp.pslverr |-> apbRsp.pready)
		else $error("slave error without ready");
	a_prdata_idle: assert property (!apbRsp.pready |-> apbRsp.prdata == 32'h0)
		else $error("read data outside answer");
	// Fault confinement
	a_busoff_cause: assert property ($rose(busOffOut) |-> $past(errEvt.txAdd8))
		else $error("bus-off without transmit error");
	a_recover_clears: assert property (errEvt.recover |=> !busOffOut)
		else $error("bus-off kept after recovery");
	// Sample point pulse shape
	a_sample_single: assert property (samplePulse |=> !samplePulse)
		else $error("sample pulse too long");
endmodule

bind cesbt_core cesbt_core_chk cesbt_core_chk_inst
(
	.sys_clk(sys_clk), .resetn(resetn), .apbReq(apbReq), .apbRsp(apbRsp), .errEvt(errEvt),
	.canRx(canRx), .quantumTick(quantumTick), .samplePulse(samplePulse),
	.sampledBit(sampledBit), .busOffOut(busOffOut)
);

`default_nettype wire

/* File: test_can_error_state_bit_timing.sv */
// Self-checking testbench for the error state and bit timing block
`timescale 1ns/1ps
`default_nettype none

module test_can_error_state_bit_timing;
	typedef struct packed {logic wr; logic [31:0] a; logic [31:0] d; logic [31:0] e; logic er;} cesbt_row_t;
	localparam logic [31:0] ST = cesbt_pkg::ADDR_STATUS;
	localparam logic [31:0] EC = cesbt_pkg::ADDR_ERRCNT;
	localparam logic [31:0] BT = cesbt_pkg::ADDR_BITTIME;
	localparam logic [5:0] TX8 = 6'h20;
	localparam logic [5:0] RX8 = 6'h04;
	localparam logic [5:0] RCV = 6'h01;

	logic                      sys_clk;     // Clock
	logic                      resetn;      // Reset
	cesbt_pkg::cesbt_apb_req_t req;         // APB request
	cesbt_pkg::cesbt_apb_rsp_t rsp;         // APB answer
	cesbt_pkg::cesbt_err_evt_t ev;          // Error events
	logic                      canRx;       // Bus pin
	logic                      dom;         // Node drives dominant
	logic                      qTick;       // Quantum pulse
	logic                      sPulse;      // Sample pulse
	logic                      sBit;        // Sampled level
	logic                      bus_off_flag;        // Bus-off
	int                        fails;       // Mismatch count
	int                        comparisons; // Compare count
	int                        n;           // Measured gap
	cesbt_row_t                rows [9];    // Ordinary cases

	cesbt_core cesbt_core_inst (.sys_clk(sys_clk), .resetn(resetn), .apbReq(req), .apbRsp(rsp),
		.errEvt(ev), .canRx(canRx), .quantumTick(qTick), .samplePulse(sPulse),
		.sampledBit(sBit), .busOffOut(bus_off_flag));
	cesbt_bus_node cesbt_bus_node_inst (.dominant(dom), .canRx(canRx));

	// Clock of 8 ns period
	always #4 sys_clk = ~sys_clk;

	// Report and end the run
	task conclude();
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Word comparison
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One APB transfer, held until ready is sampled high
	task apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		int k;
		@(posedge sys_clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge sys_clk);
		req.penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge sys_clk);
			k++;
		end
		while (rsp.pready !== 1'b1 && k < 20);
		rd = rsp.prdata;
		er = rsp.pslverr;
		req <= '0;
		if (k >= 20)
		begin
			fails++;
			conclude();
		end
	endtask

	// Read a register and compare
	task rdchk(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic        r;
		apb(1'b0, a, 32'h0, d, r);
		chk("register", e, d);
	endtask

	// Pulse an error event k times
	task evt(input logic [5:0] e, input int k);
		repeat (k)
		begin
			@(posedge sys_clk);
			ev <= e;
			@(posedge sys_clk);
			ev <= '0;
		end
	endtask

	// Cycles up to the next pulse of the quantum or sample strobe
	task gap(input bit s, output int g);
		g = 0;
		do
		begin
			@(posedge sys_clk);
			g++;
		end
		while ((s ? sPulse : qTick) !== 1'b1 && g < 400);
		if (g >= 400)
		begin
			fails++;
			conclude();
		end
	endtask

	// Main sequence
	initial
	begin
		logic [31:0] d;
		logic        r;
		sys_clk = 1'b0;
		resetn = 1'b0;
		req = '0;
		ev = '0;
		dom = 1'b0;
		fails = 0;
		comparisons = 0;
		rows[0] = '{1'b0, ST, 32'h0, 32'h0, 1'b0};
		rows[1] = '{1'b0, EC, 32'h0, 32'h0, 1'b0};
		rows[2] = '{1'b0, BT, 32'h0, 32'h2301, 1'b0};
		rows[3] = '{1'b1, BT, 32'h1ac5, 32'h0, 1'b0};
		rows[4] = '{1'b0, BT, 32'h0, 32'h2301, 1'b0};
		rows[5] = '{1'b1, 32'h40050000, 32'h41, 32'h0, 1'b0};
		rows[6] = '{1'b1, BT, 32'h1ac5, 32'h0, 1'b0};
		rows[7] = '{1'b0, BT, 32'h0, 32'h1ac5, 1'b0};
		rows[8] = '{1'b0, 32'h40050010, 32'h0, 32'h0, 1'b1};
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		foreach (rows[i])
		begin
			apb(rows[i].wr, rows[i].a, rows[i].d, d, r);
			chk("error flag", {31'h0, rows[i].er}, {31'h0, r});
			if (!rows[i].wr)
				chk("read data", rows[i].e, d);
		end
		// Leave init; prescaler 5, segments 10 and 1 give 6 and 84 clocks
		apb(1'b1, cesbt_pkg::ADDR_CONTROL, 32'h0, d, r);
		gap(1'b0, n);
		gap(1'b0, n);
		chk("quantum gap", 32'd6, n);
		gap(1'b1, n);
		gap(1'b1, n);
		chk("bit gap", 32'd84, n);
		// Falling edge lands at the first after-segment quantum: new bit starts early
		dom <= 1'b1;
		gap(1'b1, n);
		chk("resync gap", 32'd72, n);
		chk("sampled bit", 32'h0, {31'h0, sBit});
		gap(1'b1, n);
		chk("bit gap", 32'd84, n);
		dom <= 1'b0;
		// Counters through warning, passive and bus-off
		evt(TX8, 12);
		rdchk(ST, 32'h40);
		rdchk(EC, 32'h60);
		evt(TX8, 4);
		rdchk(ST, 32'h60);
		evt(RX8, 16);
		rdchk(EC, 32'h8080);
		evt(TX8, 16);
		rdchk(ST, 32'he0);
		rdchk(EC, 32'h80ff);
		chk("bus-off pin", 32'h1, {31'h0, bus_off_flag});
		evt(RCV, 1);
		rdchk(ST, 32'h0);
		evt(TX8, 3);
		// Single-step events on both counters, then three receive steps of eight
		evt(6'h10, 1);
		evt(6'h08, 2);
		evt(6'h02, 1);
		evt(RX8, 3);
		rdchk(EC, 32'h1917);
		// Reset in mid-run restores defaults
		@(posedge sys_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		rdchk(EC, 32'h0);
		rdchk(BT, 32'h2301);
		// Success while receive passive reloads below the passive level
		evt(RX8, 16);
		evt(6'h02, 1);
		rdchk(EC, 32'h7800);
		rdchk(ST, 32'h40);
		conclude();
	end
endmodule

`default_nettype wire
